//--- hw/pmon_device.sv
// Monitor end: converter sequencing, averaging, scaled results, limits, alert.
// Assumes raw samples arrive asynchronously on pins and the link is on pclk.
//
// Overview of operation
// R1: Separate shunt/bus conversion times, independent averaging; the code uses one averaging count for both shunt and bus.
// R2: Reset: wide range, continuous all-channel conversion.
// R3: Configuration registers return to reset each power-up.
// R4: Zero calibration forces current and power zero.
// R5: Host writes calibration after every power-up.
// R6: Shunt result compared with shunt high limit.
// R7: Bus result compared with bus high limit.
// R8: Power limit compares upper 16 of 24 bits.
// R9: Limits return to defaults each power-up.
// R10: Results use fixed per-count weights.
// R11: Power count is current weight times 0.2.
// R12: Results two's complement; bus never negative.
// R13: Alert selects limit event or conversion ready.
// R14: Marginal fault alerts within 0.5-1.5 conversions.
// R15: Large faults may alert after quarter conversion.
// R16: Host budgets 1.5 conversion times for alerts.
// R17: Limits and alert update when result produced.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "pmon_cfg.svh"
module pmon_device import pmon_pkg::*; #(
  parameter int CYC_PER_US = `US_NS / `CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  pmon_link.dev link,
  input wire logic [15:0] shunt_sample,
  input wire logic [15:0] bus_sample,
  input wire logic [15:0] temp_sample
);

  // ***************************************************************
  // Functions
  // ***************************************************************
  function automatic logic [19:0] ct_cycles(input logic [2:0] code);
    int us;
    case (code)
      3'h0: us = `CT_US_0;
      3'h1: us = `CT_US_1;
      3'h2: us = `CT_US_2;
      3'h3: us = `CT_US_3;
      3'h4: us = `CT_US_4;
      3'h5: us = `CT_US_5;
      3'h6: us = `CT_US_6;
      default: us = `CT_US_7;
    endcase
    return 20'(us * CYC_PER_US);
  endfunction

  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: return 4'h0;
      3'h1: return 4'h2;
      3'h2: return 4'h4;
      3'h3: return 4'h6;
      3'h4: return 4'h7;
      3'h5: return 4'h8;
      3'h6: return 4'h9;
      default: return 4'hA;
    endcase
  endfunction

  // ***************************************************************
  // Sample synchronisers
  // ***************************************************************
  logic [2:0][15:0] samp_meta_reg;
  logic [2:0][15:0] samp_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_meta_reg <= '0;
      samp_sync_reg <= '0;
    end else begin
      samp_meta_reg <= {temp_sample, bus_sample, shunt_sample};
      samp_sync_reg <= samp_meta_reg;
    end
  end

  // ***************************************************************
  // Configuration registers and link
  // ***************************************************************
  logic [15:0] config_reg, config_next;
  logic [15:0] adc_cfg_reg, adc_cfg_next;
  logic [15:0] shunt_cal_reg, shunt_cal_next;
  logic [15:0] shunt_high_limit_reg, shunt_high_limit_next;
  logic [15:0] bus_high_limit_reg, bus_high_limit_next;
  logic [15:0] power_limit_reg, power_limit_next;
  logic [15:0] alert_cfg_reg, alert_cfg_next;
  logic [23:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic diag_read;
  logic take;
  logic [15:0] vshunt_reg, current_reg, vbus_reg, temp_reg;
  logic [23:0] power_reg;
  logic [3:0] flags_reg;

  always_comb begin
    config_next = config_reg;
    adc_cfg_next = adc_cfg_reg;
    shunt_cal_next = shunt_cal_reg;
    shunt_high_limit_next = shunt_high_limit_reg;
    bus_high_limit_next = bus_high_limit_reg;
    power_limit_next = power_limit_reg;
    alert_cfg_next = alert_cfg_reg;
    rdata_next = rdata_reg;
    take = link.req && !ack_reg;
    ack_next = take;
    diag_read = take && !link.we && (link.idx == `IDX_DIAG);
    if (take && link.we) begin
      if (link.idx == `IDX_CONFIG) begin
        config_next = link.wdata;
      end else if (link.idx == `IDX_ADC_CFG) begin
        adc_cfg_next = link.wdata; // R1
      end else if (link.idx == `IDX_SHUNT_CAL) begin
        shunt_cal_next = link.wdata;
      end else if (link.idx == `IDX_SHUNT_LIM) begin
        shunt_high_limit_next = link.wdata;
      end else if (link.idx == `IDX_BUS_LIM) begin
        bus_high_limit_next = link.wdata;
      end else if (link.idx == `IDX_PWR_LIM) begin
        power_limit_next = link.wdata;
      end else if (link.idx == `IDX_ALERT_CFG) begin
        alert_cfg_next = link.wdata;
      end
    end
    if (take && !link.we) begin
      if (link.idx == `IDX_CONFIG) rdata_next = {8'h00, config_reg};
      else if (link.idx == `IDX_ADC_CFG) rdata_next = {8'h00, adc_cfg_reg};
      else if (link.idx == `IDX_SHUNT_CAL) rdata_next = {8'h00, shunt_cal_reg};
      else if (link.idx == `IDX_SHUNT_LIM) rdata_next = {8'h00, shunt_high_limit_reg};
      else if (link.idx == `IDX_BUS_LIM) rdata_next = {8'h00, bus_high_limit_reg};
      else if (link.idx == `IDX_PWR_LIM) rdata_next = {8'h00, power_limit_reg};
      else if (link.idx == `IDX_ALERT_CFG) rdata_next = {8'h00, alert_cfg_reg};
      else if (link.idx == `IDX_VSHUNT) rdata_next = {8'h00, vshunt_reg};
      else if (link.idx == `IDX_CURRENT) rdata_next = {8'h00, current_reg};
      else if (link.idx == `IDX_VBUS) rdata_next = {8'h00, vbus_reg};
      else if (link.idx == `IDX_TEMP) rdata_next = {8'h00, temp_reg};
      else if (link.idx == `IDX_POWER) rdata_next = power_reg;
      else if (link.idx == `IDX_DIAG) rdata_next = {20'h00000, flags_reg};
      else rdata_next = 24'h000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= `RST_CONFIG; // R2 R3
      adc_cfg_reg <= `RST_ADC_CFG; // R2 R3
      shunt_cal_reg <= `RST_SHUNT_CAL;
      shunt_high_limit_reg <= `RST_SHUNT_LIM; // R9
      bus_high_limit_reg <= `RST_BUS_LIM; // R9
      power_limit_reg <= `RST_PWR_LIM; // R9
      alert_cfg_reg <= `RST_ALERT_CFG;
      rdata_reg <= 24'h000000;
      ack_reg <= 1'b0;
    end else begin
      config_reg <= config_next;
      adc_cfg_reg <= adc_cfg_next;
      shunt_cal_reg <= shunt_cal_next;
      shunt_high_limit_reg <= shunt_high_limit_next;
      bus_high_limit_reg <= bus_high_limit_next;
      power_limit_reg <= power_limit_next;
      alert_cfg_reg <= alert_cfg_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  // ***************************************************************
  // Conversion sequencing, results and limits
  // ***************************************************************
  conv_phase_t phase_reg, phase_next;
  logic [19:0] tmr_reg, tmr_next;
  logic [10:0] rounds_reg, rounds_next;
  logic signed [26:0] acc_shunt_reg, acc_shunt_next;
  logic [26:0] acc_bus_reg, acc_bus_next;
  logic [15:0] vshunt_next, current_next, vbus_next, temp_next;
  logic [23:0] power_next;
  logic [3:0] flags_next;
  logic alert_reg, alert_next;
  logic [2:0] mode;
  logic [3:0] sh;
  logic [19:0] phase_len;
  logic [15:0] bus_pos, avg_shunt, avg_bus, cur_abs;
  logic signed [31:0] cur_prod;
  logic [31:0] pwr_prod;
  logic signed [15:0] cur_val;

  always_comb begin
    mode = adc_cfg_reg[`ADC_MODE_LSB +: 3];
    sh = avg_shift(adc_cfg_reg[`ADC_AVG_LSB +: 3]);
    if (phase_reg == PH_SHUNT) phase_len = ct_cycles(adc_cfg_reg[`ADC_SHUNT_CT_LSB +: 3]); // R1
    else phase_len = ct_cycles(adc_cfg_reg[`ADC_BUS_CT_LSB +: 3]); // R1
    bus_pos = samp_sync_reg[1][15] ? 16'h0000 : samp_sync_reg[1]; // R12
    avg_shunt = 16'(acc_shunt_reg >>> sh); // R10
    avg_bus = 16'(acc_bus_reg >> sh); // R10
    cur_prod = $signed(avg_shunt) * $signed({1'b0, shunt_cal_reg[14:0]}); // R4
    cur_val = config_reg[`CFG_RANGE_BIT] ? 16'(cur_prod >>> 13) : 16'(cur_prod >>> 11);
    cur_abs = cur_val[15] ? 16'(-cur_val) : cur_val;
    pwr_prod = 32'(cur_abs) * 32'(avg_bus); // R11
    phase_next = phase_reg;
    tmr_next = tmr_reg + 20'h1;
    rounds_next = rounds_reg;
    acc_shunt_next = acc_shunt_reg;
    acc_bus_next = acc_bus_reg;
    vshunt_next = vshunt_reg;
    current_next = current_reg;
    vbus_next = vbus_reg;
    temp_next = temp_reg;
    power_next = power_reg;
    flags_next = flags_reg;
    if (diag_read) flags_next[3] = 1'b0;
    if (tmr_reg >= phase_len - 20'h1) begin
      tmr_next = 20'h0;
      case (phase_reg)
        PH_SHUNT: begin
          phase_next = PH_BUS;
          if (mode[0]) begin
            acc_shunt_next = acc_shunt_reg + 27'(signed'(samp_sync_reg[0])); // R12
            if (!alert_cfg_reg[`ALERT_AVG_BIT]) begin
              flags_next[0] = $signed(samp_sync_reg[0]) > $signed(shunt_high_limit_reg); // R6 R14 R15
            end
          end
        end
        PH_BUS: begin
          phase_next = PH_TEMP;
          if (mode[1]) begin
            acc_bus_next = acc_bus_reg + 27'(bus_pos);
            if (!alert_cfg_reg[`ALERT_AVG_BIT]) begin
              flags_next[1] = bus_pos > bus_high_limit_reg; // R7 R14 R15
            end
          end
        end
        default: begin
          phase_next = PH_SHUNT;
          if (mode[2]) temp_next = samp_sync_reg[2]; // R10 R12
          if (mode != 3'b000) begin // R2
            rounds_next = rounds_reg + 11'h1;
            if (rounds_reg >= (11'h1 << sh) - 11'h1) begin // R1
              rounds_next = 11'h0;
              acc_shunt_next = '0;
              acc_bus_next = '0;
              vshunt_next = avg_shunt; // R12
              vbus_next = avg_bus; // R7 R12
              current_next = cur_val; // R4
              power_next = pwr_prod[29:6]; // R11
              flags_next[2] = pwr_prod[29:14] > power_limit_reg; // R8 R17
              if (alert_cfg_reg[`ALERT_AVG_BIT]) begin
                flags_next[0] = $signed(avg_shunt) > $signed(shunt_high_limit_reg); // R6 R17
                flags_next[1] = avg_bus > bus_high_limit_reg; // R7 R17
              end
              flags_next[3] = 1'b1;
            end
          end
        end
      endcase
    end
    if (alert_cfg_reg[`ALERT_CONV_BIT]) alert_next = flags_next[3]; // R13
    else alert_next = |flags_next[2:0]; // R13 R17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_SHUNT;
      tmr_reg <= 20'h0;
      rounds_reg <= 11'h0;
      acc_shunt_reg <= '0;
      acc_bus_reg <= '0;
      vshunt_reg <= 16'h0000;
      current_reg <= 16'h0000;
      vbus_reg <= 16'h0000;
      temp_reg <= 16'h0000;
      power_reg <= 24'h000000;
      flags_reg <= 4'h0;
      alert_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      tmr_reg <= tmr_next;
      rounds_reg <= rounds_next;
      acc_shunt_reg <= acc_shunt_next;
      acc_bus_reg <= acc_bus_next;
      vshunt_reg <= vshunt_next;
      current_reg <= current_next;
      vbus_reg <= vbus_next;
      temp_reg <= temp_next;
      power_reg <= power_next;
      flags_reg <= flags_next;
      alert_reg <= alert_next;
    end
  end

  assign link.rdata = rdata_reg;
  assign link.ack = ack_reg;
  assign link.alert = alert_reg;

endmodule // pmon_device

//--- pkg/pmon_cfg.svh
// Constants of the power monitor: link register indices, reset values, timing.
// Assumes a single 100 MHz clock shared by both ends of the link.
`ifndef PMON_CFG_SVH
`define PMON_CFG_SVH
`define CLK_PERIOD_NS 10
`define US_NS 1000
// Conversion times in microseconds, selected by a 3-bit code.
`define CT_US_0 50
`define CT_US_1 84
`define CT_US_2 150
`define CT_US_3 280
`define CT_US_4 540
`define CT_US_5 1052
`define CT_US_6 2074
`define CT_US_7 4120
// Device register indices on the link.
`define IDX_CONFIG 4'h0
`define IDX_ADC_CFG 4'h1
`define IDX_SHUNT_CAL 4'h2
`define IDX_SHUNT_LIM 4'h3
`define IDX_BUS_LIM 4'h4
`define IDX_PWR_LIM 4'h5
`define IDX_ALERT_CFG 4'h6
`define IDX_VSHUNT 4'h8
`define IDX_CURRENT 4'h9
`define IDX_VBUS 4'hA
`define IDX_TEMP 4'hB
`define IDX_POWER 4'hC
`define IDX_DIAG 4'hD
`define NUM_CFG_REGS 7
// Field positions.
`define CFG_RANGE_BIT 0
`define ADC_AVG_LSB 0
`define ADC_BUS_CT_LSB 3
`define ADC_SHUNT_CT_LSB 6
`define ADC_MODE_LSB 12
`define ALERT_CONV_BIT 0
`define ALERT_AVG_BIT 1
// Reset values.
`define RST_CONFIG 16'h0000
`define RST_ADC_CFG 16'h7168
`define RST_SHUNT_CAL 16'h0000
`define RST_SHUNT_LIM 16'h7FFF
`define RST_BUS_LIM 16'h7FFF
`define RST_PWR_LIM 16'hFFFF
`define RST_ALERT_CFG 16'h0000
// Controller APB map.
`define A_CTRL 8'h00
`define A_WDATA 8'h04
`define A_RDATA 8'h08
`define A_STATUS 8'h0C
`define A_INT_STAT 8'h10
`define A_INT_MASK 8'h14
`define CTRL_WRITE_BIT 8
`define CTRL_GO_BIT 16
`define CTRL_REPLAY_BIT 17
`endif

//--- pkg/pmon_pkg.sv
// Types shared by the power monitor ends.
// Assumes the constants header is compiled alongside.
package pmon_pkg;
  typedef enum logic [2:0] {
    PH_SHUNT = 3'b001,
    PH_BUS = 3'b010,
    PH_TEMP = 3'b100
  } conv_phase_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } xfer_state_t;
endpackage

//--- pkg/pmon_link.sv
// Register link between the controller and the monitor.
// Assumes both ends run on the same clock; no synchronisers are needed.
`timescale 1ns/1ns
interface pmon_link;
  logic req;
  logic we;
  logic [3:0] idx;
  logic [15:0] wdata;
  logic [23:0] rdata;
  logic ack;
  logic alert;
  modport dev (input req, we, idx, wdata, output rdata, ack, alert);
  modport host (output req, we, idx, wdata, input rdata, ack, alert);
endinterface

//--- hw/pmon_host.sv
// Controller end: APB slave that runs link transfers and replays setup.
// Assumes APB on pclk and the monitor on the same clock across the link.
`timescale 1ns/1ns
`include "pmon_cfg.svh"
module pmon_host import pmon_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  pmon_link.host link
);

  // ***************************************************************
  // State
  // ***************************************************************
  xfer_state_t state_reg, state_next;
  logic [15:0] shadow_reg [`NUM_CFG_REGS];
  logic [15:0] shadow_next [`NUM_CFG_REGS];
  logic [3:0] idx_reg, idx_next;
  logic we_reg, we_next;
  logic [15:0] wdata_reg, wdata_next;
  logic req_reg, req_next;
  logic replay_reg, replay_next;
  logic [23:0] rdata_reg, rdata_next;
  logic [1:0] int_stat_reg, int_stat_next;
  logic [1:0] int_mask_reg, int_mask_next;
  logic alert_prev_reg;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic apb_wr;
  logic mapped;

  always_comb begin
    state_next = state_reg;
    shadow_next = shadow_reg;
    idx_next = idx_reg;
    we_next = we_reg;
    wdata_next = wdata_reg;
    req_next = req_reg;
    replay_next = replay_reg;
    rdata_next = rdata_reg;
    int_stat_next = int_stat_reg;
    int_mask_next = int_mask_reg;
    prdata_next = prdata_reg;
    pready_next = psel && !penable;
    pslverr_next = 1'b0;
    apb_wr = psel && penable && pready_reg && pwrite;
    mapped = (paddr == `A_CTRL) || (paddr == `A_WDATA) || (paddr == `A_RDATA) ||
             (paddr == `A_STATUS) || (paddr == `A_INT_STAT) || (paddr == `A_INT_MASK);
    if (psel && !penable) begin
      pslverr_next = !mapped;
      if (paddr == `A_CTRL) prdata_next = {23'h0, we_reg, 4'h0, idx_reg};
      else if (paddr == `A_WDATA) prdata_next = {16'h0000, wdata_reg};
      else if (paddr == `A_RDATA) prdata_next = {8'h00, rdata_reg};
      else if (paddr == `A_STATUS) prdata_next = {30'h0, link.alert, state_reg == ST_XFER};
      else if (paddr == `A_INT_STAT) prdata_next = {30'h0, int_stat_reg};
      else if (paddr == `A_INT_MASK) prdata_next = {30'h0, int_mask_reg};
      else prdata_next = 32'h00000000;
    end
    if (apb_wr) begin
      if (paddr == `A_WDATA && state_reg == ST_IDLE) begin
        wdata_next = pwdata[15:0];
      end else if (paddr == `A_INT_STAT) begin
        int_stat_next = int_stat_reg & ~pwdata[1:0];
      end else if (paddr == `A_INT_MASK) begin
        int_mask_next = pwdata[1:0];
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (apb_wr && paddr == `A_CTRL && pwdata[`CTRL_REPLAY_BIT]) begin
          replay_next = 1'b1; // R3 R5 R9
          idx_next = `IDX_CONFIG;
          we_next = 1'b1;
          wdata_next = shadow_reg[0];
          req_next = 1'b1;
          state_next = ST_XFER;
        end else if (apb_wr && paddr == `A_CTRL && pwdata[`CTRL_GO_BIT]) begin
          idx_next = pwdata[3:0];
          we_next = pwdata[`CTRL_WRITE_BIT];
          req_next = 1'b1;
          state_next = ST_XFER;
          if (pwdata[`CTRL_WRITE_BIT] && pwdata[3:0] < 4'(`NUM_CFG_REGS)) begin
            shadow_next[pwdata[2:0]] = wdata_reg;
          end
        end
      end
      default: begin
        if (link.ack) begin
          if (!we_reg) rdata_next = link.rdata;
          if (replay_reg && idx_reg < 4'(`NUM_CFG_REGS - 1)) begin
            idx_next = idx_reg + 4'h1; // R3 R5 R9
            wdata_next = shadow_reg[idx_reg[2:0] + 3'h1];
          end else begin
            req_next = 1'b0;
            replay_next = 1'b0;
            state_next = ST_IDLE;
            int_stat_next[0] = 1'b1;
          end
        end
      end
    endcase
    if (link.alert && !alert_prev_reg) int_stat_next[1] = 1'b1; // R16
    irq_next = |(int_stat_next & int_mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      shadow_reg[0] <= `RST_CONFIG;
      shadow_reg[1] <= `RST_ADC_CFG;
      shadow_reg[2] <= `RST_SHUNT_CAL;
      shadow_reg[3] <= `RST_SHUNT_LIM;
      shadow_reg[4] <= `RST_BUS_LIM;
      shadow_reg[5] <= `RST_PWR_LIM;
      shadow_reg[6] <= `RST_ALERT_CFG;
      idx_reg <= 4'h0;
      we_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      req_reg <= 1'b0;
      replay_reg <= 1'b0;
      rdata_reg <= 24'h000000;
      int_stat_reg <= 2'h0;
      int_mask_reg <= 2'h0;
      alert_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shadow_reg <= shadow_next;
      idx_reg <= idx_next;
      we_reg <= we_next;
      wdata_reg <= wdata_next;
      req_reg <= req_next;
      replay_reg <= replay_next;
      rdata_reg <= rdata_next;
      int_stat_reg <= int_stat_next;
      int_mask_reg <= int_mask_next;
      alert_prev_reg <= link.alert;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign link.req = req_reg;
  assign link.we = we_reg;
  assign link.idx = idx_reg;
  assign link.wdata = wdata_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

endmodule // pmon_host

//--- dv/pmon_monitor.sv
// Link checker: handshake, result format and configuration readback.
// Assumes it sits beside the link interface on the shared clock.
`timescale 1ns/1ns
`include "pmon_cfg.svh"
module pmon_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] idx,
  input wire logic [15:0] wdata,
  input wire logic [23:0] rdata,
  input wire logic ack,
  input wire logic alert
);
  logic cal_zero_reg;
  logic cal_zero_next;
  logic [1:0] acfg_reg;
  logic [1:0] acfg_next;
  logic rd;
  assign rd = ack && !we;
  // Calibration counts as programmed once a value with nonzero bits 14:0 is written.
  always_comb begin
    cal_zero_next = cal_zero_reg;
    acfg_next = acfg_reg;
    if (ack && we && idx == `IDX_SHUNT_CAL && wdata[14:0] != 15'h0000) cal_zero_next = 1'b0;
    if (ack && we && idx == `IDX_ALERT_CFG) acfg_next = wdata[1:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_zero_reg <= 1'b1;
      acfg_reg <= 2'h0;
    end else begin
      cal_zero_reg <= cal_zero_next;
      acfg_reg <= acfg_next;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence answer_s;
    ack ##1 !ack ##1 (ack || !req);
  endsequence
  link_answer_a: assert property ($rose(req) |=> answer_s)
    else $error("link request not answered in one cycle");
  ack_cause_a: assert property (ack |-> req) else $error("ack without request");
  ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  req_hold_a: assert property (req && !ack |=> req && $stable(idx) && $stable(we)
    && $stable(wdata)) else $error("request changed before ack");
  cal_zero_a: assert property (rd && cal_zero_reg && (idx == `IDX_CURRENT
    || idx == `IDX_POWER) |-> rdata == 24'h000000) else $error("current result without cal");
  bus_sign_a: assert property (rd && idx == `IDX_VBUS |-> !rdata[15])
    else $error("negative bus result");
  narrow_read_a: assert property (rd && idx != `IDX_POWER |-> rdata[23:16] == 8'h00)
    else $error("upper bits set on narrow result");
  alert_cfg_a: assert property (rd && idx == `IDX_ALERT_CFG |-> rdata[1:0] == acfg_reg)
    else $error("alert config readback wrong");
  alert_match_a: assert property (rd && idx == `IDX_DIAG
    |-> $past(alert) == (acfg_reg[0] ? rdata[3] : |rdata[2:0]))
    else $error("alert level differs from flags");
endmodule // pmon_monitor

//--- dv/tb.sv
// Bench: APB host drives the controller, which talks to the monitor over the link.
// Assumes one 100 MHz clock and a shortened microsecond count.
`timescale 1ns/1ns
`include "pmon_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, err_seen;
  logic [15:0] vs = 16'h0000, vb = 16'h0000, vt = 16'h0000;
  int fail_count = 0, tests_run = 0;
  pmon_link link_if();
  pmon_host pmon_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link_if.host));
  pmon_device #(.CYC_PER_US(1)) pmon_device_inst(.pclk(pclk), .presetn(presetn),
    .link(link_if.dev), .shunt_sample(vs), .bus_sample(vb), .temp_sample(vt));
  pmon_monitor pmon_monitor_inst(.pclk(pclk), .presetn(presetn), .req(link_if.req),
    .we(link_if.we), .idx(link_if.idx), .wdata(link_if.wdata), .rdata(link_if.rdata),
    .ack(link_if.ack), .alert(link_if.alert));
  initial forever #5 pclk = ~pclk;
  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    fail_count++;
    $display("BAD wait exp done got timeout");
    summarize();
  endtask
  task automatic pause(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h00000000, r);
  endtask
  task automatic busy_wait();
    logic [31:0] s;
    int n;
    n = 0;
    do begin rd(`A_STATUS, s); n++; end while (s[0] !== 1'b0 && n < 50);
    if (n >= 50) timeout();
  endtask
  task automatic dwr(input logic [3:0] i, input logic [15:0] v);
    wr(`A_WDATA, {16'h0000, v});
    wr(`A_CTRL, {28'h0001010, i});
    busy_wait();
  endtask
  task automatic drd(input logic [3:0] i, output logic [23:0] v);
    logic [31:0] r;
    wr(`A_CTRL, {28'h0001000, i});
    busy_wait();
    rd(`A_RDATA, r);
    v = r[23:0];
  endtask
  task automatic t_defaults();
    logic [15:0] rv [7];
    logic [23:0] v;
    rv = '{`RST_CONFIG, `RST_ADC_CFG, `RST_SHUNT_CAL, `RST_SHUNT_LIM, `RST_BUS_LIM,
      `RST_PWR_LIM, `RST_ALERT_CFG};
    for (int i = 0; i < 7; i++) begin
      drd(4'(i), v);
      `CHK("reset value", {8'h00, rv[i]}, v)
    end
  endtask
  task automatic t_results();
    logic [23:0] v;
    dwr(`IDX_ADC_CFG, 16'h7000);
    vs <= 16'h03E8; vb <= 16'h03E8; vt <= 16'h00C8;
    pause(3500);
    drd(`IDX_VSHUNT, v); `CHK("shunt", 24'h0003E8, v)
    drd(`IDX_VBUS, v); `CHK("bus", 24'h0003E8, v)
    drd(`IDX_TEMP, v); `CHK("temp", 24'h0000C8, v)
    drd(`IDX_CURRENT, v); `CHK("current uncal", 24'h000000, v)
    drd(`IDX_POWER, v); `CHK("power uncal", 24'h000000, v)
    dwr(`IDX_SHUNT_CAL, 16'h0800);
    pause(400);
    drd(`IDX_CURRENT, v); `CHK("current", 24'h0003E8, v)
    drd(`IDX_POWER, v); `CHK("power", 24'h003D09, v)
    vs <= 16'hFC18; vb <= 16'h8000;
    pause(400);
    drd(`IDX_VSHUNT, v); `CHK("neg shunt", 24'h00FC18, v)
    drd(`IDX_CURRENT, v); `CHK("neg current", 24'h00FC18, v)
    drd(`IDX_VBUS, v); `CHK("neg bus", 24'h000000, v)
    vs <= 16'h03E8; vb <= 16'h03E8;
  endtask
  task automatic t_limits();
    logic [23:0] v;
    logic [31:0] r;
    int n;
    wr(`A_INT_MASK, 32'h00000002);
    wr(`A_INT_STAT, 32'h00000003);
    dwr(`IDX_SHUNT_LIM, 16'h01F4); pause(400);
    drd(`IDX_DIAG, v); `CHK("shunt fault", 3'b001, v[2:0])
    rd(`A_STATUS, r); `CHK("alert", 1'b1, r[1])
    `CHK("irq", 1'b1, irq)
    wr(`A_INT_STAT, 32'h00000002); pause(2);
    `CHK("irq clear", 1'b0, irq)
    dwr(`IDX_SHUNT_LIM, 16'h7FFF); dwr(`IDX_BUS_LIM, 16'h01F4); pause(400);
    drd(`IDX_DIAG, v); `CHK("bus fault", 3'b010, v[2:0])
    dwr(`IDX_BUS_LIM, 16'h7FFF); dwr(`IDX_PWR_LIM, 16'h003C); pause(400);
    drd(`IDX_DIAG, v); `CHK("power fault", 3'b100, v[2:0])
    dwr(`IDX_PWR_LIM, 16'h003D); dwr(`IDX_SHUNT_LIM, 16'h03E8); pause(400);
    drd(`IDX_DIAG, v); `CHK("at limits", 3'b000, v[2:0])
    @(posedge pclk);
    vs <= 16'h03E9;
    n = 0;
    while (link_if.alert !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
    `CHK("alert latency", 1'b1, n <= 230)
    pause(2); `CHK("irq rise", 1'b1, irq)
    wr(`A_INT_MASK, 32'h00000000); pause(2);
    `CHK("irq masked", 1'b0, irq)
    rd(8'h20, r); `CHK("unmapped", 1'b1, err_seen)
  endtask
  task automatic t_ready();
    logic [23:0] v;
    int n;
    dwr(`IDX_ALERT_CFG, 16'h0001); pause(400);
    n = 0;
    fork
      drd(`IDX_DIAG, v);
      while (link_if.alert !== 1'b0 && n < 200) begin @(posedge pclk); n++; end
    join
    `CHK("ready bit", 1'b1, v[3])
    `CHK("alert cleared", 1'b1, n < 200)
    n = 0;
    while (link_if.alert !== 1'b1 && n < 200) begin @(posedge pclk); n++; end
    `CHK("ready alert", 1'b1, n < 200)
    dwr(`IDX_ALERT_CFG, 16'h0002);
    drd(`IDX_ALERT_CFG, v); `CHK("avg compare sel", 24'h000002, v)
  endtask
  task automatic t_reset();
    logic [23:0] v;
    logic [31:0] r;
    dwr(`IDX_SHUNT_LIM, 16'h03E9); pause(400);
    drd(`IDX_DIAG, v); `CHK("avg compare", 3'b000, v[2:0])
    dwr(`IDX_CONFIG, 16'h0001); dwr(`IDX_SHUNT_LIM, 16'h1234);
    wr(`A_INT_STAT, 32'h00000003); wr(`A_CTRL, 32'h00020000); busy_wait();
    rd(`A_INT_STAT, r); `CHK("replay done", 1'b1, r[0])
    drd(`IDX_SHUNT_LIM, v); `CHK("replay limit", 24'h001234, v)
    @(posedge pclk);
    presetn <= 1'b0;
    pause(3);
    presetn <= 1'b1;
    t_defaults();
    pause(3500);
    drd(`IDX_VSHUNT, v); `CHK("free running", 24'h0003E9, v)
  endtask
  initial begin
    pause(6);
    presetn <= 1'b1;
    t_defaults();
    t_results();
    t_limits();
    t_ready();
    t_reset();
    summarize();
  end
endmodule // tb
